// file: tarfag_adc_model.sv
`timescale 1ns/10ps
module tarfag_adc_model (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              conv_start,
   input  wire logic              adc_req,
   input  wire logic              slow,
   input  wire logic [15:0][11:0] samples,
   output tarfag_pkg::tarfag_adc_t adc_ret
);
   int          idx;
   int          wcnt;
   logic [11:0] last;
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         idx <= 0;
         wcnt <= 0;
         last <= 12'h000;
         adc_ret <= '0;
      end else begin
         // data bus shows junk outside a reply, never the held sample
         adc_ret <= {1'b0, ~last};
         if (conv_start)
            idx <= 0;
         if (adc_req)
            wcnt <= slow ? 4 : 1;
         else if (wcnt == 1) begin
            adc_ret <= {1'b1, samples[idx]};
            last <= samples[idx];
            idx <= idx + 1;
            wcnt <= 0;
         end else if (wcnt > 1)
            wcnt <= wcnt - 1;
      end
   end
endmodule

// file: tarfag_filter.sv
`timescale 1ns/10ps
// Notes on behaviour
// - rank window code 00 off, 01 four, 10 eight, 11 sixteen samples.
// - window larger than mean count: samples kept sorted ascending, smallest first, largest last.
// - mean count code 00 two, 01 four, 10 eight, 11 sixteen.
// - window larger than mean count: average the centre group of sorted samples.
// - result register takes only the finished mean, never partial values.
// - both codes zero: one conversion passed through unfiltered.
// - window equal to mean count: no sorting, mean of all samples.
// - each sorted insertion costs about two microseconds extra.
// - channel address 011 selects auxiliary, 010 selects battery.
// - pin function bit picks I/O or analog; I/O bits inert while analog.
// - auxiliary and battery results share one result register.
// - battery divider powered only while the battery input is sampled.
// - each auxiliary or battery result is checked against upper and lower limits.
// - separate sticky status bits for upper and lower violations.
// - limit status drives the interrupt pin in alarm mode, gated by enables.
// - direction 0 drives the pin from data; direction 1 reads pin into data.
// - polarity 1 keeps levels, polarity 0 inverts both ways.
// - alert mask 0 lets the I/O pin interrupt, 1 blocks it.
// - I/O interrupt only as input with data set and interrupt enabled.
// - I/O interrupt holds until pin input or I/O enable bit changes.
// - no sorting time when the rank window is off.
module tarfag_filter (
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [15:0]          reg_wdata,
   output logic      [15:0]          reg_rdata,
   input  wire logic                 conv_start,
   output logic                      adc_req,
   output logic      [2:0]           adc_chan,
   input  wire tarfag_pkg::tarfag_adc_t adc_ret,
   output logic                      result_done,
   output logic                      batt_div_en,
   output logic                      aux_analog_sel,
   input  wire logic                 gpio_in,
   output logic                      gpio_out,
   output logic                      gpio_oe,
   output logic                      shared_irq_pin_n
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [15:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next, ctrl3_reg, ctrl3_next;
   logic [15:0] upper_reg, upper_next, lower_reg, lower_next, result_reg, result_next;
   logic [15:0] rdata_reg, rdata_next;
   tarfag_pkg::tarfag_state_t state_reg, state_next;
   logic [11:0] arr_reg [tarfag_pkg::MAX_SAMPLES];
   logic [11:0] arr_next [tarfag_pkg::MAX_SAMPLES];
   logic [4:0]  cnt_reg, cnt_next, idx_reg, idx_next;
   logic [5:0]  wait_reg, wait_next;
   logic [15:0] sum_reg, sum_next;
   logic        req_reg, req_next, done_reg, done_next, batt_reg, batt_next;
   logic [2:0]  sync_reg;
   logic        gpio_irq_reg, gpio_irq_next, pin_seen_reg, pin_seen_next;
   logic        en_seen_reg, en_seen_next, irq_n_reg, irq_n_next;
   logic        out_reg, out_next, oe_reg, oe_next, ana_reg, ana_next;

   // ------------------------------------------------------------
   // filter sizing
   // ------------------------------------------------------------
   logic [1:0]  rank_code, mean_code;
   logic [2:0]  n_log, a_log;
   logic [4:0]  n_tot, a_tot, first_idx;
   logic        do_sort, aux_batt, pin_lvl;
   logic [15:0] mean_val;

   always_comb begin
      rank_code = ctrl2_reg[tarfag_pkg::C2_RANK_HI:tarfag_pkg::C2_RANK_LO];
      mean_code = ctrl2_reg[tarfag_pkg::C2_MEAN_HI:tarfag_pkg::C2_MEAN_LO];
      a_log = 3'(mean_code) + 3'h1;
      if (rank_code == 2'h0) begin
         // window off: single pass-through when mean code is also zero
         n_log = (mean_code == 2'h0) ? 3'h0 : a_log;
         if (mean_code == 2'h0) begin
            a_log = 3'h0;
         end
      end else begin
         n_log = 3'(rank_code) + 3'h1;
      end
      // unsupported window below mean count is clamped, never overruns
      if (a_log > n_log) begin
         a_log = n_log;
      end
      n_tot     = 5'(1 << n_log);
      a_tot     = 5'(1 << a_log);
      first_idx = 5'((n_tot - a_tot) >> 1);
      do_sort   = (rank_code != 2'h0) && (n_log != a_log);
      mean_val  = sum_reg >> a_log;
      aux_batt  = (ctrl1_reg[tarfag_pkg::C1_CHAN_HI:tarfag_pkg::C1_CHAN_LO]
                   == tarfag_pkg::CHAN_AUX) ||
                  (ctrl1_reg[tarfag_pkg::C1_CHAN_HI:tarfag_pkg::C1_CHAN_LO]
                   == tarfag_pkg::CHAN_BATT);
   end

   // ------------------------------------------------------------
   // conversion, ranking and averaging
   // ------------------------------------------------------------
   logic keep [tarfag_pkg::MAX_SAMPLES];
   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      idx_next    = idx_reg;
      wait_next   = wait_reg;
      sum_next    = sum_reg;
      req_next    = 1'b0;
      done_next   = 1'b0;
      result_next = result_reg;
      for (int i = 0; i < tarfag_pkg::MAX_SAMPLES; i++) begin
         arr_next[i] = arr_reg[i];
         keep[i]     = (5'(i) < cnt_reg) && (arr_reg[i] <= adc_ret.data);
      end
      case (state_reg)
         tarfag_pkg::ST_IDLE: begin
            if (conv_start) begin
               cnt_next   = 5'h0;
               req_next   = 1'b1;
               state_next = tarfag_pkg::ST_CONV;
            end
         end
         tarfag_pkg::ST_CONV: begin
            if (adc_ret.done) begin
               if (do_sort) begin
                  // insertion keeps the array ascending
                  for (int i = 0; i < tarfag_pkg::MAX_SAMPLES; i++) begin
                     if (!keep[i]) begin
                        arr_next[i] = (i == 0 || keep[i > 0 ? i - 1 : 0]) ?
                                      adc_ret.data : arr_reg[i > 0 ? i - 1 : 0];
                     end
                  end
                  wait_next  = 6'(tarfag_pkg::SORT_CYCLES);
                  state_next = tarfag_pkg::ST_SORT;
               end else begin
                  arr_next[cnt_reg[3:0]] = adc_ret.data;
                  state_next = tarfag_pkg::ST_SORT;
                  wait_next  = 6'h0;
               end
               cnt_next = cnt_reg + 5'h1;
            end
         end
         tarfag_pkg::ST_SORT: begin
            if (wait_reg > 6'h1) begin
               wait_next = wait_reg - 6'h1;
            end else if (cnt_reg >= n_tot) begin
               idx_next   = first_idx;
               sum_next   = 16'h0;
               state_next = tarfag_pkg::ST_SUM;
            end else begin
               req_next   = 1'b1;
               state_next = tarfag_pkg::ST_CONV;
            end
         end
         tarfag_pkg::ST_SUM: begin
            sum_next = sum_reg + 16'(arr_reg[idx_reg[3:0]]);
            idx_next = idx_reg + 5'h1;
            if (idx_reg + 5'h1 >= first_idx + a_tot) begin
               state_next = tarfag_pkg::ST_DONE;
            end
         end
         tarfag_pkg::ST_DONE: begin
            // only the finished mean reaches the result register
            if (aux_batt) begin
               result_next = mean_val;
            end
            done_next  = 1'b1;
            state_next = tarfag_pkg::ST_IDLE;
         end
         default: state_next = tarfag_pkg::ST_IDLE;
      endcase
      // divider on only while a battery sample is being taken
      batt_next = (state_next == tarfag_pkg::ST_CONV) && !ctrl2_reg[tarfag_pkg::C2_PIN_GPIO] &&
                  (ctrl1_reg[tarfag_pkg::C1_CHAN_HI:tarfag_pkg::C1_CHAN_LO]
                   == tarfag_pkg::CHAN_BATT);
   end

   // ------------------------------------------------------------
   // registers, limits and pin
   // ------------------------------------------------------------
   logic hi_evt, lo_evt, alarm;
   always_comb begin
      ctrl1_next = ctrl1_reg;
      ctrl2_next = ctrl2_reg;
      ctrl3_next = ctrl3_reg;
      upper_next = upper_reg;
      lower_next = lower_reg;
      rdata_next = rdata_reg;
      pin_lvl    = sync_reg[2];
      hi_evt = (state_reg == tarfag_pkg::ST_DONE) && aux_batt && (mean_val > upper_reg);
      lo_evt = (state_reg == tarfag_pkg::ST_DONE) && aux_batt && (mean_val < lower_reg);
      if (reg_wr) begin
         if (reg_addr == tarfag_pkg::ADDR_CTRL1) begin
            ctrl1_next = reg_wdata;
         end else if (reg_addr == tarfag_pkg::ADDR_CTRL2) begin
            ctrl2_next = reg_wdata;
            if (ctrl2_reg[tarfag_pkg::C2_GPIO_DIR]) begin
               ctrl2_next[tarfag_pkg::C2_GPIO_DATA] = ctrl2_reg[tarfag_pkg::C2_GPIO_DATA];
            end
         end else if (reg_addr == tarfag_pkg::ADDR_CTRL3) begin
            // status bits clear by writing one
            ctrl3_next = reg_wdata & ~16'h0003;
            ctrl3_next[1:0] = ctrl3_reg[1:0] & ~reg_wdata[1:0];
         end else if (reg_addr == tarfag_pkg::ADDR_UPPER) begin
            upper_next = reg_wdata;
         end else if (reg_addr == tarfag_pkg::ADDR_LOWER) begin
            lower_next = reg_wdata;
         end
      end
      // hardware set wins over a same-cycle clear
      if (hi_evt) ctrl3_next[tarfag_pkg::C3_HI_STAT] = 1'b1;
      if (lo_evt) ctrl3_next[tarfag_pkg::C3_LO_STAT] = 1'b1;
      if (ctrl2_reg[tarfag_pkg::C2_PIN_GPIO] && ctrl2_reg[tarfag_pkg::C2_GPIO_DIR]) begin
         ctrl2_next[tarfag_pkg::C2_GPIO_DATA] =
            ctrl2_reg[tarfag_pkg::C2_POL] ? pin_lvl : !pin_lvl;
      end
      if (reg_rd) begin
         if (reg_addr == tarfag_pkg::ADDR_CTRL1) begin
            rdata_next = ctrl1_reg;
         end else if (reg_addr == tarfag_pkg::ADDR_CTRL2) begin
            rdata_next = ctrl2_reg;
         end else if (reg_addr == tarfag_pkg::ADDR_CTRL3) begin
            rdata_next = ctrl3_reg;
         end else if (reg_addr == tarfag_pkg::ADDR_UPPER) begin
            rdata_next = upper_reg;
         end else if (reg_addr == tarfag_pkg::ADDR_LOWER) begin
            rdata_next = lower_reg;
         end else if (reg_addr == tarfag_pkg::ADDR_RESULT) begin
            rdata_next = result_reg;
         end else begin
            rdata_next = 16'h0000;
         end
      end
      // pin drivers: inert while the pin is analog
      ana_next = !ctrl2_reg[tarfag_pkg::C2_PIN_GPIO];
      oe_next  = ctrl2_reg[tarfag_pkg::C2_PIN_GPIO] && !ctrl2_reg[tarfag_pkg::C2_GPIO_DIR];
      out_next = oe_next && (ctrl2_reg[tarfag_pkg::C2_POL] ?
                 ctrl2_reg[tarfag_pkg::C2_GPIO_DATA] : !ctrl2_reg[tarfag_pkg::C2_GPIO_DATA]);
      // latched pin interrupt released by a pin or enable change
      pin_seen_next = pin_lvl;
      en_seen_next  = ctrl2_reg[tarfag_pkg::C2_PIN_GPIO];
      gpio_irq_next = gpio_irq_reg;
      if ((pin_lvl != pin_seen_reg) || (ctrl2_reg[tarfag_pkg::C2_PIN_GPIO] != en_seen_reg)) begin
         gpio_irq_next = 1'b0;
      end else if (ctrl2_reg[tarfag_pkg::C2_PIN_GPIO] && ctrl2_reg[tarfag_pkg::C2_GPIO_DIR] &&
                   ctrl2_reg[tarfag_pkg::C2_GPIO_DATA] && !ctrl3_reg[tarfag_pkg::C3_GPIO_MASK] &&
                   ctrl1_reg[tarfag_pkg::C1_ALARM_SEL]) begin
         gpio_irq_next = 1'b1;
      end
      alarm = ctrl1_reg[tarfag_pkg::C1_ALARM_SEL] &&
              ((ctrl3_reg[tarfag_pkg::C3_HI_STAT] && ctrl3_reg[tarfag_pkg::C3_HI_EN]) ||
               (ctrl3_reg[tarfag_pkg::C3_LO_STAT] && ctrl3_reg[tarfag_pkg::C3_LO_EN]));
      irq_n_next = !(alarm || gpio_irq_reg);
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= tarfag_pkg::ST_IDLE;
         for (int i = 0; i < tarfag_pkg::MAX_SAMPLES; i++) begin
            arr_reg[i] <= 12'h000;
         end
         cnt_reg      <= 5'h0;
         idx_reg      <= 5'h0;
         wait_reg     <= 6'h0;
         sum_reg      <= 16'h0000;
         req_reg      <= 1'b0;
         done_reg     <= 1'b0;
         batt_reg     <= 1'b0;
         result_reg   <= tarfag_pkg::LIMIT_RST;
         ctrl1_reg    <= tarfag_pkg::CTRL1_RST;
         ctrl2_reg    <= tarfag_pkg::CTRL2_RST;
         ctrl3_reg    <= tarfag_pkg::CTRL3_RST;
         upper_reg    <= tarfag_pkg::LIMIT_RST;
         lower_reg    <= tarfag_pkg::LIMIT_RST;
         rdata_reg    <= 16'h0000;
         sync_reg     <= 3'h0;
         pin_seen_reg <= 1'b0;
         en_seen_reg  <= 1'b0;
         gpio_irq_reg <= 1'b0;
         irq_n_reg    <= 1'b1;
         out_reg      <= 1'b0;
         oe_reg       <= 1'b0;
         ana_reg      <= 1'b1;
      end else begin
         state_reg    <= state_next;
         arr_reg      <= arr_next;
         cnt_reg      <= cnt_next;
         idx_reg      <= idx_next;
         wait_reg     <= wait_next;
         sum_reg      <= sum_next;
         req_reg      <= req_next;
         done_reg     <= done_next;
         batt_reg     <= batt_next;
         result_reg   <= result_next;
         ctrl1_reg    <= ctrl1_next;
         ctrl2_reg    <= ctrl2_next;
         ctrl3_reg    <= ctrl3_next;
         upper_reg    <= upper_next;
         lower_reg    <= lower_next;
         rdata_reg    <= rdata_next;
         sync_reg     <= {sync_reg[1:0], gpio_in};
         // a pin change counts once the second and third stages agree
         if (sync_reg[1] == sync_reg[2]) begin
            pin_seen_reg <= pin_seen_next;
         end
         en_seen_reg  <= en_seen_next;
         gpio_irq_reg <= gpio_irq_next;
         irq_n_reg    <= irq_n_next;
         out_reg      <= out_next;
         oe_reg       <= oe_next;
         ana_reg      <= ana_next;
      end
   end

   assign reg_rdata        = rdata_reg;
   assign adc_req          = req_reg;
   assign adc_chan         = ctrl1_reg[tarfag_pkg::C1_CHAN_HI:tarfag_pkg::C1_CHAN_LO];
   assign result_done      = done_reg;
   assign batt_div_en      = batt_reg;
   assign aux_analog_sel   = ana_reg;
   assign gpio_out         = out_reg;
   assign gpio_oe          = oe_reg;
   assign shared_irq_pin_n = irq_n_reg;
endmodule

// file: tarfag_filter_chk.sv
`timescale 1ns/10ps
module tarfag_filter_chk (
   input wire logic                    clk_sys,
   input wire logic                    sys_rst,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [15:0]             reg_rdata,
   input wire logic                    adc_req,
   input wire logic [2:0]              adc_chan,
   input wire tarfag_pkg::tarfag_adc_t adc_ret,
   input wire logic                    result_done,
   input wire logic                    batt_div_en,
   input wire logic                    aux_analog_sel,
   input wire logic                    gpio_oe,
   input wire logic                    shared_irq_pin_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic [6:0] since_done;
   // saturates so a long idle spell never wraps into the legal window
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         since_done <= 7'h7F;
      else if (adc_ret.done)
         since_done <= 7'h00;
      else if (since_done != 7'h7F)
         since_done <= since_done + 7'h01;
   end
   property p_req_pulse;
      adc_req |=> !adc_req;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("adc_req wider than one cycle");
   property p_done_gap;
      adc_ret.done |=> !adc_req;
   endproperty
   a_done_gap: assert property (p_done_gap) else $error("request right after sample");
   property p_res_lat;
      result_done |-> since_done inside {[2:70]};
   endproperty
   a_res_lat: assert property (p_res_lat) else $error("result timing off");
   property p_res_pulse;
      result_done |=> !result_done;
   endproperty
   a_res_pulse: assert property (p_res_pulse) else $error("result_done not a pulse");
   property p_rdata_hold;
      !$past(reg_rd) |-> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_pin_analog;
      aux_analog_sel |-> !gpio_oe;
   endproperty
   a_pin_analog: assert property (p_pin_analog) else $error("pin driven in analog mode");
   property p_batt_div;
      batt_div_en |-> adc_chan == tarfag_pkg::CHAN_BATT && aux_analog_sel;
   endproperty
   a_batt_div: assert property (p_batt_div) else $error("divider on wrongly");
   property p_irq_cause;
      $fell(shared_irq_pin_n) |-> result_done || $past(result_done) || $past(result_done, 2)
         || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3) || !aux_analog_sel;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
endmodule
bind tarfag_filter tarfag_filter_chk u_chk (.clk_sys, .sys_rst, .reg_wr, .reg_rd, .reg_rdata,
   .adc_req, .adc_chan, .adc_ret, .result_done, .batt_div_en, .aux_analog_sel, .gpio_oe,
   .shared_irq_pin_n);

// file: tarfag_pkg.sv
package tarfag_pkg;
   // ------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL1   = 8'h01;
   localparam logic [7:0]  ADDR_CTRL2   = 8'h02;
   localparam logic [7:0]  ADDR_CTRL3   = 8'h03;
   localparam logic [7:0]  ADDR_UPPER   = 8'h04;
   localparam logic [7:0]  ADDR_LOWER   = 8'h05;
   localparam logic [7:0]  ADDR_RESULT  = 8'h0C;
   localparam logic [15:0] CTRL1_RST    = 16'h0000;
   localparam logic [15:0] CTRL2_RST    = 16'h4040;
   localparam logic [15:0] CTRL3_RST    = 16'h0000;
   localparam logic [15:0] LIMIT_RST    = 16'h0000;
   // control 1
   localparam int C1_ALARM_SEL = 15;
   localparam int C1_CHAN_HI   = 14;
   localparam int C1_CHAN_LO   = 12;
   // control 2
   localparam int C2_PIN_GPIO  = 13;
   localparam int C2_GPIO_DATA = 12;
   localparam int C2_GPIO_DIR  = 11;
   localparam int C2_POL       = 10;
   localparam int C2_MEAN_HI   = 8;
   localparam int C2_MEAN_LO   = 7;
   localparam int C2_RANK_HI   = 6;
   localparam int C2_RANK_LO   = 5;
   // control 3
   localparam int C3_GPIO_MASK = 12;
   localparam int C3_HI_EN     = 9;
   localparam int C3_LO_EN     = 8;
   localparam int C3_HI_STAT   = 1;
   localparam int C3_LO_STAT   = 0;
   localparam logic [2:0] CHAN_BATT = 3'h2;
   localparam logic [2:0] CHAN_AUX  = 3'h3;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SORT_TIME_NS  = 2000;
   localparam int SORT_CYCLES   = SORT_TIME_NS / CLK_PERIOD_NS;
   localparam int MAX_SAMPLES   = 16;

   typedef struct packed {
      logic        done;
      logic [11:0] data;
   } tarfag_adc_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CONV = 5'h02,
      ST_SORT = 5'h04,
      ST_SUM  = 5'h08,
      ST_DONE = 5'h10
   } tarfag_state_t;
endpackage

// file: tb.sv
`timescale 1ns/10ps
module tb;
   logic clk_sys, sys_rst, reg_wr, reg_rd, conv_start, adc_req, result_done;
   logic batt_div_en, aux_analog_sel, gpio_in, gpio_out, gpio_oe, shared_irq_pin_n;
   logic slow, batt_seen, hi, lo;
   logic [7:0]              reg_addr;
   logic [15:0]             reg_wdata, reg_rdata, rv;
   logic [2:0]              adc_chan, ch, g;
   logic [1:0]              r, m, en;
   logic [11:0]             e;
   logic [31:0]             rng;
   logic [15:0][11:0]       samples;
   tarfag_pkg::tarfag_adc_t adc_ret;
   int                      miscompares, n_tests, cyc;
   logic [7:0]              ra [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0C, 8'h07};
   logic [15:0]             rx [7] = '{16'h0000, 16'h4040, 16'h0000, 16'h0000, 16'h0000,
                                       16'h0000, 16'h0000};
   tarfag_filter DUT (.clk_sys, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .conv_start, .adc_req, .adc_chan, .adc_ret, .result_done, .batt_div_en, .aux_analog_sel,
      .gpio_in, .gpio_out, .gpio_oe, .shared_irq_pin_n);
   tarfag_adc_model u_adc (.clk_sys, .sys_rst, .conv_start, .adc_req, .slow, .samples, .adc_ret);
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [11:0] exp_res(input logic [1:0] rc, input logic [1:0] mc,
                                          input logic [15:0][11:0] s);
      logic [11:0] a [16];
      logic [11:0] t;
      logic [17:0] sum;
      int          n;
      int          k;
      k = 2 << mc;
      n = (rc != 2'h0) ? (2 << rc) : ((mc != 2'h0) ? k : 1);
      for (int i = 0; i < 16; i++)
         a[i] = s[i];
      for (int i = 0; i < n; i++)
         for (int j = 0; j + 1 < n - i; j++)
            if (a[j] > a[j+1]) begin
               t = a[j];
               a[j] = a[j+1];
               a[j+1] = t;
            end
      if (n == 1)
         return a[0];
      sum = 18'h00000;
      for (int i = (n - k) / 2; i < (n + k) / 2; i++)
         sum += 18'(a[i]);
      return 12'(sum >> (mc + 1));
   endfunction
   // edges from the sampled start to the edge that raises result_done
   function automatic int exp_cyc(input logic [1:0] rc, input logic [1:0] mc, input logic sl);
      int n;
      int a;
      int s;
      a = 2 << mc;
      n = (rc != 2'h0) ? (2 << rc) : ((mc != 2'h0) ? a : 1);
      if (n == 1)
         a = 1;
      s = (rc != 2'h0 && n != a) ? tarfag_pkg::SORT_CYCLES : 1;
      // the partner's answer is taken three edges after a request, six when slow
      return n * ((sl ? 6 : 3) + s) + 1 + a;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic conv(output int cyc);
      int i;
      batt_seen = 1'b0;
      @(negedge clk_sys);
      conv_start = 1'b1;
      @(negedge clk_sys);
      conv_start = 1'b0;
      for (i = 0; i < 3000 && result_done !== 1'b1; i++) begin
         @(negedge clk_sys);
         batt_seen |= batt_div_en;
      end
      if (i == 3000)
         chk(16'h0001, 16'h0000);
      cyc = i;
   endtask
   task automatic finish_test;
      if (miscompares == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // longest run is about 10k cycles; this limit only cuts a hang short
   initial begin
      repeat (100000) @(posedge clk_sys);
      miscompares++;
      finish_test();
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, conv_start, gpio_in, slow} = 6'h20;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      samples = '0;
      rng = 32'h4CFD;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      wr(8'h07, 16'hFFFF);
      for (int i = 0; i < 7; i++) begin
         rd(ra[i], rv);
         chk(rv, rx[i]);
      end
      for (int it = 0; it < 40; it++) begin
         r = it[1:0];
         m = it[3:2];
         if (r != 2'h0 && r < m)
            continue;
         ch = it[4] ? tarfag_pkg::CHAN_AUX : tarfag_pkg::CHAN_BATT;
         for (int i = 0; i < 16; i++) begin
            rng = xs(rng);
            samples[i] = (it < 4) ? 12'hFFF - 12'(i) : rng[11:0];
         end
         rng = xs(rng);
         slow = rng[15];
         en = rng[31:30];
         wr(8'h04, {4'h0, rng[11:0]});
         wr(8'h05, {4'h0, rng[27:16]});
         wr(8'h03, {6'h00, en, 8'h03});
         wr(8'h02, {7'h00, m, r, 5'h00});
         wr(8'h01, {1'b1, ch, 12'h000});
         conv(cyc);
         chk(16'(cyc), 16'(exp_cyc(r, m, slow)));
         chk({13'h0, adc_chan}, {13'h0, ch});
         e = exp_res(r, m, samples);
         hi = e > rng[11:0];
         lo = e < rng[27:16];
         rd(8'h0C, rv);
         chk(rv, {4'h0, e});
         chk({14'h0, batt_seen, batt_div_en}, {14'h0, ch == tarfag_pkg::CHAN_BATT, 1'b0});
         rd(8'h03, rv);
         chk({14'h0, rv[1:0]}, {14'h0, hi, lo});
         chk({15'h0, shared_irq_pin_n}, {15'h0, !((hi & en[1]) | (lo & en[0]))});
      end
      wr(8'h03, 16'h1003);
      for (int i = 0; i < 8; i++) begin
         g = i[2:0];
         gpio_in = g[0];
         wr(8'h02, {3'h1, g[0], g[2], g[1], 10'h000});
         repeat (6) @(negedge clk_sys);
         rd(8'h02, rv);
         chk({gpio_oe, g[2] ? rv[12] : gpio_out, aux_analog_sel},
             {!g[2], g[1] ? g[0] : !g[0], 1'b0});
      end
      wr(8'h02, 16'h1400);
      repeat (3) @(negedge clk_sys);
      chk({gpio_oe, gpio_out, aux_analog_sel}, 16'h0001);
      wr(8'h01, 16'h8000);
      wr(8'h03, 16'h0000);
      wr(8'h02, 16'h3400);
      repeat (8) @(negedge clk_sys);
      chk({15'h0, shared_irq_pin_n}, 16'h0001);
      gpio_in = 1'b1;
      wr(8'h02, 16'h2C00);
      repeat (8) @(negedge clk_sys);
      chk({15'h0, shared_irq_pin_n}, 16'h0000);
      gpio_in = 1'b0;
      repeat (8) @(negedge clk_sys);
      chk({15'h0, shared_irq_pin_n}, 16'h0001);
      wr(8'h03, 16'h1000);
      gpio_in = 1'b1;
      repeat (8) @(negedge clk_sys);
      chk({15'h0, shared_irq_pin_n}, 16'h0001);
      finish_test();
   end
endmodule
